// ===== hw/phy_vendor_regs.sv
// vendor status, event and control registers behind the serial management port
`timescale 1ns/1ps
module phy_vendor_regs (
	input wire logic clock,
	input wire logic rstn,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic [4:0] strap_phyad,
	input wire logic strap_xover_dis,
	input wire logic strap_scr_byp,
	input wire logic rx_dv,
	input wire logic rx_er,
	input wire logic [7:0] event_pulse,
	input wire logic energy_det,
	input wire logic link_ok,
	input wire logic an_done,
	input wire logic flow_ok,
	input wire logic isolated,
	input wire logic [2:0] op_mode,
	output logic xover_dis,
	output logic force_link,
	output logic link_pass,
	output logic pwr_save,
	output logic jabber_en,
	output logic sqe_test,
	output logic scr_bypass,
	output logic int_pin
);
	import phy_vendor_pkg::*;
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////////
	// pin synchronisers: first stage feeds only the second
	logic [3:0] pin_s1_r;
	logic [3:0] pin_s2_r;
	logic [6:0] strap_s1_r;
	logic [6:0] strap_s2_r;
	logic mdc_d_r;
	logic dv_d_r;
	logic mdc_rise;
	logic mdio_s;
	logic dv_s;
	logic er_s;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pin_s1_r <= 4'h0;
			pin_s2_r <= 4'h0;
			strap_s1_r <= 7'h00;
			strap_s2_r <= 7'h00;
			mdc_d_r <= 1'h0;
			dv_d_r <= 1'h0;
		end else begin
			pin_s1_r <= {mdc, mdio_in, rx_dv, rx_er};
			pin_s2_r <= pin_s1_r;
			strap_s1_r <= {strap_phyad, strap_xover_dis, strap_scr_byp};
			strap_s2_r <= strap_s1_r;
			mdc_d_r <= pin_s2_r[3];
			dv_d_r <= pin_s2_r[1];
		end
	end
	assign mdc_rise = pin_s2_r[3] & ~mdc_d_r;
	assign mdio_s = pin_s2_r[2];
	assign dv_s = pin_s2_r[1];
	assign er_s = pin_s2_r[0];
	////////////////////////////////////////////////////////////////////
	// receive error tally: one count per errored packet, wraps at 16 bits
	logic [15:0] rxerr_cnt_r;
	logic [15:0] rxerr_cnt_nxt;
	logic err_seen_r;
	logic err_seen_nxt;
	logic pkt_end;
	logic pkt_err;
	always_comb begin
		pkt_end = dv_d_r & ~dv_s;
		pkt_err = pkt_end & err_seen_r;
		err_seen_nxt = pkt_end ? 1'h0 : (err_seen_r | (er_s & dv_s));
		rxerr_cnt_nxt = pkt_err ? rxerr_cnt_r + 16'h0001 : rxerr_cnt_r;
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rxerr_cnt_r <= RXERR_RST;
			err_seen_r <= 1'h0;
		end else begin
			rxerr_cnt_r <= rxerr_cnt_nxt;
			err_seen_r <= err_seen_nxt;
		end
	end
	////////////////////////////////////////////////////////////////////
	// management frame engine
	mgmt_state_t st_r;
	mgmt_state_t st_nxt;
	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic [11:0] hdr_r;
	logic [11:0] hdr_nxt;
	logic [15:0] sh_r;
	logic [15:0] sh_nxt;
	logic oe_r;
	logic oe_nxt;
	logic dout_r;
	logic dout_nxt;
	logic wr_stb;
	logic rd_cap;
	logic [15:0] wdata;
	logic [4:0] phyad_r;
	logic addr_hit;
	logic int_pol_r;
	flag_if fi();
	function automatic logic [15:0] read_word(input logic [4:0] ra);
		logic [15:0] w;
		w = 16'h0000;
		if (ra == REG_RXERR) begin
			w = rxerr_cnt_r;
		end else if (ra == REG_EVT) begin
			w = {fi.en, fi.flags};
		end else if (ra == REG_CTL) begin
			w[CTL_XOVER_DIS] = xover_dis;
			w[CTL_ENERGY] = energy_det;
			w[CTL_FORCE_LINK] = force_link;
			w[CTL_PWR_SAVE] = pwr_save;
			w[CTL_INT_POL] = int_pol_r;
			w[CTL_JABBER_EN] = jabber_en;
			w[CTL_AN_DONE] = an_done;
			w[CTL_FLOW] = flow_ok;
			w[CTL_ISOLATE] = isolated;
			w[CTL_MODE_LSB+:3] = op_mode;
			w[CTL_SQE] = sqe_test;
			w[CTL_SCR_BYP] = scr_bypass;
		end
		return w;
	endfunction
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		hdr_nxt = hdr_r;
		sh_nxt = sh_r;
		oe_nxt = oe_r;
		dout_nxt = dout_r;
		wr_stb = 1'h0;
		rd_cap = 1'h0;
		wdata = {sh_r[14:0], mdio_s};
		addr_hit = hdr_r[9:5] == phyad_r;
		if (mdc_rise) begin
			case (st_r)
			ST_PRE: begin
				if (mdio_s) begin
					cnt_nxt = (cnt_r == PRE_LEN) ? cnt_r : cnt_r + 6'h01;
				end else if (cnt_r == PRE_LEN) begin
					st_nxt = ST_START;
					cnt_nxt = 6'h00;
				end else begin
					cnt_nxt = 6'h00;
				end
			end
			ST_START: begin
				cnt_nxt = 6'h00;
				st_nxt = mdio_s ? ST_HDR : ST_PRE;
			end
			ST_HDR: begin
				hdr_nxt = {hdr_r[10:0], mdio_s};
				cnt_nxt = cnt_r + 6'h01;
				if (cnt_r == HDR_LAST) begin
					st_nxt = ST_TA;
					cnt_nxt = 6'h00;
				end
			end
			ST_TA: begin
				if (cnt_r == 6'h00) begin
					cnt_nxt = 6'h01;
					if (addr_hit && hdr_r[11:10] == OP_RD) begin
						rd_cap = 1'h1;
						sh_nxt = read_word(hdr_r[4:0]);
						oe_nxt = 1'h1;
						dout_nxt = 1'h0;
					end
				end else begin
					st_nxt = ST_DATA;
					cnt_nxt = 6'h00;
					dout_nxt = sh_r[15];
					sh_nxt = {sh_r[14:0], 1'h0};
				end
			end
			ST_DATA: begin
				cnt_nxt = cnt_r + 6'h01;
				if (oe_r) begin
					dout_nxt = sh_r[15];
					sh_nxt = {sh_r[14:0], 1'h0};
				end else begin
					sh_nxt = wdata;
				end
				if (cnt_r == DATA_LAST) begin
					st_nxt = ST_PRE;
					cnt_nxt = 6'h00;
					oe_nxt = 1'h0;
					dout_nxt = 1'h0;
					wr_stb = addr_hit && hdr_r[11:10] == OP_WR && !oe_r;
				end
			end
			default: begin
				st_nxt = ST_PRE;
				cnt_nxt = 6'h00;
				oe_nxt = 1'h0;
			end
			endcase
		end
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_r <= ST_PRE;
			cnt_r <= 6'h00;
			hdr_r <= 12'h000;
			sh_r <= 16'h0000;
			oe_r <= 1'h0;
			dout_r <= 1'h0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			hdr_r <= hdr_nxt;
			sh_r <= sh_nxt;
			oe_r <= oe_nxt;
			dout_r <= dout_nxt;
		end
	end
	assign mdio_oe = oe_r;
	assign mdio_out = dout_r;
	////////////////////////////////////////////////////////////////////
	// writable controls, event enables and strap capture
	logic [7:0] evt_en_r;
	logic [7:0] evt_en_nxt;
	logic [5:0] ctl_r;
	logic [5:0] ctl_nxt;
	logic int_pol_nxt;
	logic [1:0] strap_cnt_r;
	logic [1:0] strap_cnt_nxt;
	logic [4:0] phyad_nxt;
	logic int_nxt;
	logic int_r;
	// ctl_r holds xover, force, power save, jabber, sqe, scrambler bypass
	always_comb begin
		evt_en_nxt = evt_en_r;
		ctl_nxt = ctl_r;
		int_pol_nxt = int_pol_r;
		phyad_nxt = phyad_r;
		strap_cnt_nxt = strap_cnt_r;
		// straps settle through the synchroniser before they are taken
		if (strap_cnt_r != 2'h3) begin
			strap_cnt_nxt = strap_cnt_r + 2'h1;
		end
		if (strap_cnt_r == STRAP_WAIT) begin
			phyad_nxt = strap_s2_r[6:2];
			ctl_nxt[5] = strap_s2_r[1];
			ctl_nxt[0] = strap_s2_r[0];
		end
		if (wr_stb && hdr_r[4:0] == REG_EVT) begin
			evt_en_nxt = wdata[15:EVT_EN_LSB];
		end else if (wr_stb && hdr_r[4:0] == REG_CTL) begin
			ctl_nxt = {wdata[CTL_XOVER_DIS], wdata[CTL_FORCE_LINK],
				wdata[CTL_PWR_SAVE], wdata[CTL_JABBER_EN],
				wdata[CTL_SQE], wdata[CTL_SCR_BYP]};
			int_pol_nxt = wdata[CTL_INT_POL];
		end
		int_nxt = int_pol_r ? fi.irq : ~fi.irq;
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			evt_en_r <= EVT_EN_RST;
			ctl_r <= {XOVER_DIS_RST, FORCE_LINK_RST, PWR_SAVE_RST,
				JABBER_EN_RST, SQE_RST, SCR_BYP_RST};
			int_pol_r <= INT_POL_RST;
			phyad_r <= PHYAD_RST;
			strap_cnt_r <= 2'h0;
			int_r <= 1'h1;
		end else begin
			evt_en_r <= evt_en_nxt;
			ctl_r <= ctl_nxt;
			int_pol_r <= int_pol_nxt;
			phyad_r <= phyad_nxt;
			strap_cnt_r <= strap_cnt_nxt;
			int_r <= int_nxt;
		end
	end
	assign {xover_dis, force_link, pwr_save, jabber_en, sqe_test,
		scr_bypass} = ctl_r;
	assign link_pass = link_ok | force_link;
	assign int_pin = int_r;
	////////////////////////////////////////////////////////////////////
	// event flags; jabber events are dropped while jabber detection is off
	always_comb begin
		fi.evt = event_pulse;
		fi.evt[EVT_JABBER] = event_pulse[EVT_JABBER] & jabber_en;
		fi.evt[EVT_RXERR] = event_pulse[EVT_RXERR] | pkt_err;
		fi.en = evt_en_r;
		// only flags returned by this read are cleared
		fi.clr = (rd_cap && hdr_r[4:0] == REG_EVT) ? fi.flags : 8'h00;
	end
	event_flags u_flags (
		.clock(clock),
		.rstn(rstn),
		.fl(fi.bank)
	);
	////////////////////////////////////////////////////////////////////
	sequence s_ctl_write;
		wr_stb && hdr_r[4:0] == REG_CTL;
	endsequence
	sequence s_evt_write;
		wr_stb && hdr_r[4:0] == REG_EVT;
	endsequence
	AST_RXERR_INC: assert property (pkt_err |=>
		rxerr_cnt_r == $past(rxerr_cnt_r) + 16'h0001)
		else $error("errored packet not counted");
	AST_EN_WRITE: assert property (s_evt_write |=>
		evt_en_r == $past(wdata[15:8]))
		else $error("event enables not written");
	AST_INT_LEVEL: assert property (##1
		int_pin == ($past(int_pol_r) ? $past(fi.irq) : !$past(fi.irq)))
		else $error("interrupt pin level wrong for polarity");
	AST_XOVER_WRITE: assert property (s_ctl_write |=>
		xover_dis == $past(wdata[13]))
		else $error("crossover disable not written");
	AST_READ_STATUS: assert property (
		rd_cap && hdr_r[4:0] == REG_CTL |=>
		sh_r[12] == $past(energy_det) && sh_r[4:2] == $past(op_mode))
		else $error("status captured wrong");
	AST_LINK_PASS: assert property (force_link |-> link_pass)
		else $error("forced link not passing");
	AST_PWR_WRITE: assert property (s_ctl_write |=>
		pwr_save == $past(wdata[10]) ##1 $stable(pwr_save))
		else $error("power saving control lost");
	AST_JAB_GATE: assert property (!jabber_en |->
		!fi.evt[EVT_JABBER])
		else $error("jabber event passed while disabled");
	AST_SQE_WRITE: assert property (s_ctl_write |=>
		sqe_test == $past(wdata[1]) && scr_bypass == $past(wdata[0]))
		else $error("sqe or scrambler control not written");
endmodule // phy_vendor_regs

// ===== common/phy_vendor_pkg.sv
// constants and types for the vendor status and control register bank
// Notes on behaviour
// - count received packets carrying error; reset zero
// - event enables in bits 15..8, reset zero
// - event flags in bits 7..0, same order
// - flags read-only, cleared after read returns them
// - control bit picks interrupt pin polarity, low default
// - control bit disables automatic crossover, reset zero
// - status bit shows energy on receive pair
// - forced link treats link as passing
// - power saving control bit, resets to one
// - jabber detection enable bit, resets to one
// - status bit shows auto-negotiation completed
// - status bit shows resolved flow control
// - status bit shows isolate mode
// - three-bit status field shows operating mode
// - SQE test enable bit, reset zero
// - scrambler bypass bit, reset zero
// - some defaults come from strap pins
package phy_vendor_pkg;
	localparam logic [4:0] REG_RXERR = 5'h15;
	localparam logic [4:0] REG_EVT = 5'h1B;
	localparam logic [4:0] REG_CTL = 5'h1F;
	localparam int EVT_EN_LSB = 8;
	localparam int EVT_JABBER = 7;
	localparam int EVT_RXERR = 6;
	localparam int CTL_XOVER_DIS = 13;
	localparam int CTL_ENERGY = 12;
	localparam int CTL_FORCE_LINK = 11;
	localparam int CTL_PWR_SAVE = 10;
	localparam int CTL_INT_POL = 9;
	localparam int CTL_JABBER_EN = 8;
	localparam int CTL_AN_DONE = 7;
	localparam int CTL_FLOW = 6;
	localparam int CTL_ISOLATE = 5;
	localparam int CTL_MODE_LSB = 2;
	localparam int CTL_SQE = 1;
	localparam int CTL_SCR_BYP = 0;
	localparam logic [15:0] RXERR_RST = 16'h0000;
	localparam logic [7:0] EVT_EN_RST = 8'h00;
	localparam logic [7:0] EVT_FLAG_RST = 8'h00;
	localparam logic XOVER_DIS_RST = 1'h0;
	localparam logic FORCE_LINK_RST = 1'h0;
	localparam logic PWR_SAVE_RST = 1'h1;
	localparam logic INT_POL_RST = 1'h0;
	localparam logic JABBER_EN_RST = 1'h1;
	localparam logic SQE_RST = 1'h0;
	localparam logic SCR_BYP_RST = 1'h0;
	localparam logic [4:0] PHYAD_RST = 5'h00;
	localparam logic [5:0] PRE_LEN = 6'h20;
	localparam logic [5:0] HDR_LAST = 6'h0B;
	localparam logic [5:0] DATA_LAST = 6'h0F;
	localparam logic [1:0] OP_RD = 2'h2;
	localparam logic [1:0] OP_WR = 2'h1;
	localparam logic [1:0] STRAP_WAIT = 2'h2;
	typedef enum logic [2:0] {
		ST_PRE = 3'h0,
		ST_START = 3'h1,
		ST_HDR = 3'h3,
		ST_TA = 3'h2,
		ST_DATA = 3'h6
	} mgmt_state_t;
endpackage

// ===== common/flag_if.sv
// event flag bank connection between register core and flag keeper
`timescale 1ns/1ps
interface flag_if;
	logic [7:0] evt;
	logic [7:0] en;
	logic [7:0] clr;
	logic [7:0] flags;
	logic irq;
	modport bank (input evt, input en, input clr, output flags, output irq);
	modport core (output evt, output en, output clr, input flags, input irq);
endinterface

// ===== hw/event_flags.sv
// sticky event flags with clear-on-read and enabled interrupt request
`timescale 1ns/1ps
module event_flags (
	input wire logic clock,
	input wire logic rstn,
	flag_if.bank fl
);
	import phy_vendor_pkg::*;
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!rstn);

	logic [7:0] flags_r;
	logic [7:0] flags_nxt;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		// a new event wins over the clear of the same bit
		flags_nxt = (flags_r & ~fl.clr) | fl.evt;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			flags_r <= EVT_FLAG_RST;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	assign fl.flags = flags_r;
	assign fl.irq = |(flags_r & fl.en);

	////////////////////////////////////////////////////////////////////
	AST_FLAG_SET: assert property ((|fl.evt) |=>
		((flags_r & $past(fl.evt)) == $past(fl.evt)))
		else $error("event did not set its flag");
	AST_FLAG_CLR: assert property ((|(fl.clr & ~fl.evt)) |=>
		((flags_r & $past(fl.clr & ~fl.evt)) == 8'h00))
		else $error("read flag was not cleared");
	AST_IRQ: assert property (fl.irq == (|(fl.flags & fl.en)))
		else $error("interrupt request disagrees with enabled flags");
endmodule // event_flags

// ===== bench/mgmt_host.sv
// station management host model driving the serial management pins
`timescale 1ns/1ps
module mgmt_host (
	input wire logic clock,
	output logic mdc,
	output logic mdio_in,
	input wire logic mdio_out,
	input wire logic mdio_oe
);
	logic drv_en = 1'b0;
	logic drv_bit = 1'b0;
	// nobody driving: the pull-up wins, so a silent device reads as ones
	assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv_bit : 1'b1);
	initial mdc = 1'b0;
	////////////////////////////////////////
	// half period of five clocks outlasts the two synchroniser stages and the edge detect
	task automatic half();
		repeat (5) @(posedge clock);
		#1;
	endtask
	task automatic tick();
		half();
		mdc = 1'b1;
		half();
		mdc = 1'b0;
	endtask
	task automatic put(input logic b);
		drv_en = 1'b1;
		drv_bit = b;
		tick();
	endtask
	task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
		input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [13:0] hdr;
		hdr = {2'b01, op, pa, ra};
		rd = 16'h0000;
		repeat (32) put(1'b1);
		for (int i = 13; i >= 0; i--) put(hdr[i]);
		if (op == 2'h2) begin
			drv_en = 1'b0;
			tick();
			// sample at the end of the low half, just before the rise
			for (int i = 16; i >= 0; i--) begin
				half();
				if (i < 16) rd[i] = mdio_in;
				mdc = 1'b1;
				half();
				mdc = 1'b0;
			end
		end else begin
			put(1'b1);
			put(1'b0);
			for (int i = 15; i >= 0; i--) put(wd[i]);
		end
		drv_en = 1'b0;
		tick();
	endtask
endmodule // mgmt_host

// ===== bench/phy_vendor_status_interrupt_regs_bench.sv
// self-checking bench for the vendor status and event register bank
`timescale 1ns/1ps
module phy_vendor_status_interrupt_regs_bench;
	import phy_vendor_pkg::*;
	localparam logic [4:0] PA = 5'h05;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic mdc, mdio_in, mdio_out, mdio_oe;
	logic rx_dv = 1'b0;
	logic rx_er = 1'b0;
	logic [7:0] event_pulse = 8'h00;
	logic energy_det = 1'b1;
	logic link_ok = 1'b0;
	logic an_done = 1'b0;
	logic flow_ok = 1'b1;
	logic isolated = 1'b0;
	logic [2:0] op_mode = 3'h6;
	logic xover_dis, force_link, link_pass, pwr_save, jabber_en;
	logic sqe_test, scr_bypass, int_pin;
	logic [15:0] rw = 16'h2501;
	logic [15:0] d;
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	always #20 clock = ~clock;
	phy_vendor_regs u_dut (.clock(clock), .rstn(rstn), .mdc(mdc),
		.mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.strap_phyad(PA), .strap_xover_dis(1'b1), .strap_scr_byp(1'b1),
		.rx_dv(rx_dv), .rx_er(rx_er), .event_pulse(event_pulse),
		.energy_det(energy_det), .link_ok(link_ok), .an_done(an_done),
		.flow_ok(flow_ok), .isolated(isolated), .op_mode(op_mode),
		.xover_dis(xover_dis), .force_link(force_link),
		.link_pass(link_pass), .pwr_save(pwr_save), .jabber_en(jabber_en),
		.sqe_test(sqe_test), .scr_bypass(scr_bypass), .int_pin(int_pin));
	mgmt_host u_host (.clock(clock), .mdc(mdc), .mdio_in(mdio_in),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe));
	////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			final_report();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic rd(input logic [4:0] ra, output logic [15:0] v);
		u_host.xfer(OP_RD, PA, ra, 16'h0000, v);
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] v);
		u_host.xfer(OP_WR, PA, ra, v, d);
	endtask
	task automatic ctl_chk();
		logic [15:0] o;
		o = {2'b00, xover_dis, 1'b0, force_link, pwr_save, 1'b0, jabber_en,
			6'h00, sqe_test, scr_bypass};
		chk(o, rw & 16'h2D03);
		chk({15'h0000, int_pin}, {15'h0000, ~rw[9]});
		rd(REG_CTL, d);
		chk(d, (rw & 16'h2F03) | {3'h0, energy_det, 4'h0, an_done, flow_ok,
			isolated, op_mode, 2'h0});
		chk({15'h0000, link_pass}, {15'h0000, rw[11] | link_ok});
	endtask
	task automatic pulse(input logic [7:0] m);
		event_pulse = m;
		wait_clk(1);
		event_pulse = 8'h00;
		wait_clk(3);
	endtask
	////////////////////////////////////////
	task automatic t_reset();
		ctl_chk();
		rd(REG_RXERR, d);
		chk(d, 16'h0000);
		rd(REG_EVT, d);
		chk(d, 16'h0000);
		$display("reset test done");
	endtask
	task automatic t_ctl();
		logic [15:0] v [4] = '{16'hFFFF, 16'h0000, 16'h2A02, 16'h0300};
		for (int m = 0; m < 8; m++) begin
			wr(REG_CTL, v[m % 4]);
			rw = v[m % 4];
			op_mode = m[2:0];
			an_done = m[0];
			isolated = m[1];
			flow_ok = m[2];
			energy_det = ~m[0];
			link_ok = m[1];
			ctl_chk();
		end
		$display("control test done");
	endtask
	task automatic t_events();
		logic [7:0] en;
		logic [7:0] oth;
		for (int i = 0; i < 8; i++) begin
			en = 8'h01 << i;
			oth = 8'h01 << ((i + 1) % 8);
			wr(REG_EVT, {en, 8'hFF});
			pulse(oth);
			chk({15'h0000, int_pin}, 16'h0000);
			pulse(en);
			chk({15'h0000, int_pin}, 16'h0001);
			rd(REG_EVT, d);
			chk(d, {en, en | oth});
			rd(REG_EVT, d);
			chk(d, {en, 8'h00});
			chk({15'h0000, int_pin}, 16'h0000);
		end
		// detection off drops jabber events; pin now active low
		wr(REG_CTL, 16'h0000);
		rw = 16'h0000;
		wr(REG_EVT, 16'h8100);
		pulse(8'h81);
		chk({15'h0000, int_pin}, 16'h0000);
		rd(REG_EVT, d);
		chk(d, 16'h8101);
		chk({15'h0000, int_pin}, 16'h0001);
		wr(REG_CTL, 16'h0300);
		rw = 16'h0300;
		$display("event test done");
	endtask
	task automatic pkt(input logic err);
		rx_dv = 1'b1;
		wait_clk(4);
		rx_er = err;
		wait_clk(2);
		rx_er = 1'b0;
		wait_clk(4);
		rx_dv = 1'b0;
		wait_clk(8);
	endtask
	task automatic t_rxerr();
		wr(REG_EVT, 16'h4000);
		pkt(1'b1);
		pkt(1'b0);
		pkt(1'b1);
		chk({15'h0000, int_pin}, 16'h0001);
		rd(REG_RXERR, d);
		chk(d, 16'h0002);
		rd(REG_EVT, d);
		chk(d, 16'h4040);
		$display("error count test done");
	endtask
	task automatic t_refuse();
		// a foreign address must leave the wire to the pull-up
		u_host.xfer(OP_RD, 5'h06, REG_CTL, 16'h0000, d);
		chk(d, 16'hFFFF);
		u_host.xfer(OP_WR, 5'h06, REG_CTL, 16'h0000, d);
		wr(REG_RXERR, 16'h1234);
		rd(5'h10, d);
		chk(d, 16'h0000);
		rd(REG_RXERR, d);
		chk(d, 16'h0002);
		ctl_chk();
		$display("refusal test done");
	endtask
	initial begin
		repeat (20) @(posedge clock);
		#1;
		rstn = 1'b1;
		wait_clk(10);
		t_reset();
		t_ctl();
		t_events();
		t_rxerr();
		t_refuse();
		final_report();
	end
endmodule // phy_vendor_status_interrupt_regs_bench
